/* File: bench/ssrw_host_model.sv */
// Purpose : host side that strobes the supervisor watchdog on request
// Assumes : kick is sampled on the rising clock edge
// Notes   : a held kick toggles every cycle, the fastest legal rate
`timescale 1ns/1ps
`default_nettype none

module ssrw_host_model (
  input  wire logic clock,
  input  wire logic kick,
  output var  logic watchdog_strobe_in
);
  // either edge is a strobe, so a plain toggle covers both directions
  initial watchdog_strobe_in = 1'b0;
  always @(posedge clock) begin
    if (kick) watchdog_strobe_in <= ~watchdog_strobe_in;
  end
endmodule : ssrw_host_model

`default_nettype wire

/* File: bench/tb_top.sv */
// Purpose : self-checking bench of the supply supervisor
// Assumes : shortened counts, a six-channel and a four-channel build side by side
// Notes   : a cycle model is compared with every output at each falling edge
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  localparam int CH = 6;
  localparam int CQ = 4;
  localparam int RH = 20;
  localparam int OH = 5;
  localparam int WI = 40;
  localparam int WN = 10;
  // ------------------------------------------------------------------
  // signals
  // ------------------------------------------------------------------
  logic clock, rst, clk_en, mr_n, hold_n, kick, strobe;
  logic rn, roe, ovn, ovoe, wdn, wdoe;
  logic rnq, roeq, ovnq, ovoeq, wdnq, wdoeq;
  ssrw_pkg::ssrw_chan_t [CH-1:0] chans;
  int err_total, total_checks, rc, oc, wc, cyc, i, rq, oq;
  logic seen, prev, primed, er, eo, ew, erq, eoq;
  logic [31:0] seed;

  ssrw_supervisor #(.CHANNELS(CH), .RST_HOLD_CYC(RH), .OV_HOLD_CYC(OH),
    .WD_INIT_CYC(WI), .WD_NORM_CYC(WN)) ssrw_supervisor_i (
    .clock(clock), .rst(rst), .clk_en(clk_en), .monitor_channel(chans),
    .manual_reset_req_n(mr_n), .hold_state_n(hold_n), .watchdog_strobe_in(strobe),
    .system_reset_n(rn), .system_reset_oe(roe), .overvoltage_alarm_n(ovn),
    .overvoltage_alarm_oe(ovoe), .watchdog_expired_n(wdn), .watchdog_expired_oe(wdoe));

  ssrw_host_model ssrw_host_model_i (.clock(clock), .kick(kick), .watchdog_strobe_in(strobe));

  // quad build sees only the first four channels of the same stimulus
  ssrw_supervisor #(.CHANNELS(CQ), .RST_HOLD_CYC(RH), .OV_HOLD_CYC(OH),
    .WD_INIT_CYC(WI), .WD_NORM_CYC(WN)) ssrw_supervisor_quad_i (
    .clock(clock), .rst(rst), .clk_en(clk_en), .monitor_channel(chans[CQ-1:0]),
    .manual_reset_req_n(mr_n), .hold_state_n(hold_n), .watchdog_strobe_in(strobe),
    .system_reset_n(rnq), .system_reset_oe(roeq), .overvoltage_alarm_n(ovnq),
    .overvoltage_alarm_oe(ovoeq), .watchdog_expired_n(wdnq), .watchdog_expired_oe(wdoeq));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs

  function automatic logic anyf(input ssrw_pkg::ssrw_chan_t [CH-1:0] c, input logic ov,
                                input int nch);
    for (int k = 0; k < nch; k++) if (ov ? c[k].over_v : c[k].under_v) return 1'b1;
    return 1'b0;
  endfunction : anyf

  // ------------------------------------------------------------------
  // reference model: counts only on live edges, history on enabled ones
  // ------------------------------------------------------------------
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      rc = RH; oc = OH; wc = 0; seen = 0; primed = 0; er = 0; eo = 0; ew = 1;
      rq = RH; oq = OH; erq = 0; eoq = 0;
    end else if (clk_en) begin
      if (hold_n) begin
        if (anyf(chans, 1'b0, CH) || !mr_n) rc = RH; else if (rc > 0) rc--;
        er = (rc == 0);
        if (anyf(chans, 1'b1, CH)) oc = OH; else if (oc > 0) oc--;
        eo = (oc == 0);
        // quad build: channels five and six must not reach it
        if (anyf(chans, 1'b0, CQ) || !mr_n) rq = RH; else if (rq > 0) rq--;
        erq = (rq == 0);
        if (anyf(chans, 1'b1, CQ)) oq = OH; else if (oq > 0) oq--;
        eoq = (oq == 0);
        if (primed && strobe !== prev) begin
          wc = 0; seen = 1; ew = 1;
        end else begin
          if (wc < (seen ? WN : WI)) wc++;
          if (wc == (seen ? WN : WI)) ew = 0;
        end
      end
      prev = strobe;
      primed = 1;
    end
  end

  task automatic chk(input string nm, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %b seen %b", nm, e, g);
    end
  endtask : chk

  task automatic finish_test();
    if (err_total == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test

  // drive one input set at the rising edge and hold it n cycles
  task automatic step(input logic [11:0] ch, input logic mr, hd, en, kk, input int n);
    @(posedge clock);
    chans <= ch; mr_n <= mr; hold_n <= hd; clk_en <= en; kick <= kk;
    repeat (n - 1) @(posedge clock);
  endtask : step

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // compare where outputs are settled; also bounds the whole run
  always @(negedge clock) begin
    chk("system_reset_n", er, rn);
    chk("system_reset_oe", ~er, roe);
    chk("overvoltage_alarm_n", eo, ovn);
    chk("overvoltage_alarm_oe", ~eo, ovoe);
    chk("watchdog_expired_n", ew, wdn);
    chk("watchdog_expired_oe", ~ew, wdoe);
    chk("quad system_reset_n", erq, rnq);
    chk("quad system_reset_oe", ~erq, roeq);
    chk("quad overvoltage_alarm_n", eoq, ovnq);
    chk("quad overvoltage_alarm_oe", ~eoq, ovoeq);
    chk("quad watchdog_expired_n", ew, wdnq);
    chk("quad watchdog_expired_oe", ~ew, wdoeq);
    cyc++;
    if (cyc > 100000) begin
      err_total++;
      finish_test();
    end
  end

  initial begin
    seed = 32'hFCB22FFB; rst = 1; clk_en = 1; mr_n = 1; hold_n = 1; kick = 0;
    chans = '0; err_total = 0; total_checks = 0; cyc = 0;
    repeat (2) @(posedge clock);
    rst <= 0;
    // power-up stretches and the long first timeout
    step('0, 1, 1, 1, 0, WI + 4);
    // every channel and flag alone, each followed by full recovery
    for (i = 0; i < 2 * CH; i++) begin
      step(12'h001 << i, 1, 1, 1, 0, 3);
      step('0, 1, 1, 1, 0, RH + 2);
    end
    // manual reset, back-to-back strobes, then the short timeout
    step('0, 0, 1, 1, 0, 4);
    step('0, 1, 1, 1, 1, 3);
    // long enough for the reset to release too, so the freeze below starts with it high
    step('0, 1, 1, 1, 0, RH + 3);
    // freeze wins over manual reset and undervoltage
    step(12'h002, 0, 0, 1, 1, RH + 5);
    step('0, 1, 1, 1, 0, RH + 3);
    step(12'h001, 1, 1, 0, 0, 5);
    // random traffic with rare causes and a strobe on about one step in sixteen
    repeat (1500) begin
      seed = xs(seed);
      step((seed[7:0] < 8'h0C) ? (12'h001 << seed[11:8]) : 12'h000, seed[15:12] != 4'h0,
           seed[20:16] != 5'h00, seed[23:21] != 3'h0, seed[27:24] == 4'h0, 1);
    end
    // reset in mid-run restores the power-up behaviour
    @(posedge clock);
    rst <= 1;
    // quiet inputs, so no leftover kick turns the first timeout into a normal one
    chans <= '0;
    mr_n <= 1'b1;
    hold_n <= 1'b1;
    clk_en <= 1'b1;
    kick <= 1'b0;
    repeat (2) @(posedge clock);
    rst <= 0;
    step('0, 1, 1, 1, 0, WI + 2);
    finish_test();
  end
endmodule : tb_top

`default_nettype wire

/* File: include/ssrw_pkg.sv */
//----------------------------------------------------------------------
// Purpose : constants and carrier types of the supply supervisor
// Assumes : core clock of 125 MHz
// Notes   : times stay in their printed units; cycle counts derive here
//----------------------------------------------------------------------
package ssrw_pkg;

  // ------------------------------------------------------------------
  // clock and printed times
  // ------------------------------------------------------------------
  localparam longint unsigned CLK_HZ      = 125_000_000;
  localparam longint unsigned RST_HOLD_MS = 200;     // reset stretch
  localparam longint unsigned OV_HOLD_US  = 25;      // alarm stretch, typical
  localparam longint unsigned WD_INIT_MS  = 102_400; // 102.4 s initial timeout
  localparam longint unsigned WD_NORM_MS  = 1_600;   // 1.6 s normal timeout

  // ------------------------------------------------------------------
  // derived cycle counts: least times round up, timeouts round down
  // ------------------------------------------------------------------
  localparam longint unsigned RST_HOLD_CYC = (RST_HOLD_MS * CLK_HZ + 999) / 1000;
  localparam longint unsigned OV_HOLD_CYC  = (OV_HOLD_US * CLK_HZ + 999_999) / 1_000_000;
  localparam longint unsigned WD_INIT_CYC  = (WD_INIT_MS * CLK_HZ) / 1000;
  localparam longint unsigned WD_NORM_CYC  = (WD_NORM_MS * CLK_HZ) / 1000;

  // ------------------------------------------------------------------
  // variants and output levels
  // ------------------------------------------------------------------
  localparam int unsigned CH_QUAD = 4;
  localparam int unsigned CH_HEX  = 6;
  localparam logic        OUT_ON  = 1'b0; // active-low asserted
  localparam logic        OUT_OFF = 1'b1;

  // one monitored channel: two comparator results
  typedef struct packed {
    logic under_v; // below low threshold
    logic over_v;  // above high threshold
  } ssrw_chan_t;

endpackage : ssrw_pkg

/* File: verilog/ssrw_stretch.sv */
//----------------------------------------------------------------------
// Purpose : holds an alarm active for COUNT cycles after its cause ends
// Assumes : cause synchronous to clock
// Notes   : power-up starts with the alarm active and a full count
//----------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none

module ssrw_stretch #(
  parameter longint unsigned COUNT = 16
) (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic step,   // clock enable and not frozen
  input  wire logic cause,
  output var  logic active
);

  localparam int CW = $clog2(COUNT + 1);

  generate
    if (COUNT < 1) begin : g_bad
      $error("ssrw_stretch: COUNT must be at least one");
    end
  endgenerate

  logic [CW-1:0] cnt_r;
  logic          active_r;

  // ------------------------------------------------------------------
  // stretch counter: reload while the cause stands, then count down
  // ------------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_r    <= CW'(COUNT);
      active_r <= 1'b1;
    end else if (step) begin
      if (cause) begin
        cnt_r    <= CW'(COUNT);
        active_r <= 1'b1;
      end else if (cnt_r != '0) begin
        cnt_r    <= cnt_r - 1'b1;
        active_r <= (cnt_r != CW'(1));
      end
    end
  end

  assign active = active_r;

endmodule : ssrw_stretch

`default_nettype wire

/* File: verilog/ssrw_supervisor.sv */
//----------------------------------------------------------------------
// Purpose : supply supervisor: reset, overvoltage alarm and watchdog
// Assumes : comparator flags and pins synchronous to clock; rst = power-up
// Notes   : outputs are open drain, driven as level plus pull-down enable
//----------------------------------------------------------------------
// Function
// - Build with four or six monitored channels, each with its own comparator.
// - Every channel delivers separate undervoltage and overvoltage flags.
// - Reset output low on any undervoltage or manual reset request low.
// - Reset stays asserted 200 ms after all its causes clear.
// - Overvoltage alarm low while any channel is over its high threshold.
// - Overvoltage alarm stays asserted 25 us after all channels recover.
// - Watchdog has an initial 102.4 s and a normal 1.6 s timeout.
// - Watchdog-expired output goes low when the active timeout elapses.
// - Either strobe edge releases watchdog-expired and restarts the count.
// - Hold-state low freezes all three outputs at their current levels.
// - Hold-state wins over a simultaneous manual reset request.
`timescale 1ns/1ps
`default_nettype none

module ssrw_supervisor #(
  parameter int unsigned     CHANNELS     = ssrw_pkg::CH_HEX,
  parameter longint unsigned RST_HOLD_CYC = ssrw_pkg::RST_HOLD_CYC,
  parameter longint unsigned OV_HOLD_CYC  = ssrw_pkg::OV_HOLD_CYC,
  parameter longint unsigned WD_INIT_CYC  = ssrw_pkg::WD_INIT_CYC,
  parameter longint unsigned WD_NORM_CYC  = ssrw_pkg::WD_NORM_CYC
) (
  input  wire logic                                clock,
  input  wire logic                                rst,
  input  wire logic                                clk_en,
  input  wire ssrw_pkg::ssrw_chan_t [CHANNELS-1:0] monitor_channel,
  input  wire logic                                manual_reset_req_n,
  input  wire logic                                hold_state_n,
  input  wire logic                                watchdog_strobe_in,
  output var  logic                                system_reset_n,
  output var  logic                                system_reset_oe,
  output var  logic                                overvoltage_alarm_n,
  output var  logic                                overvoltage_alarm_oe,
  output var  logic                                watchdog_expired_n,
  output var  logic                                watchdog_expired_oe
);

  localparam int WD_W = $clog2(WD_INIT_CYC + 1);

  // ------------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------------
  generate
    if (CHANNELS != ssrw_pkg::CH_QUAD && CHANNELS != ssrw_pkg::CH_HEX) begin : g_bad_ch
      $error("ssrw_supervisor: CHANNELS must be 4 or 6");
    end
    if (WD_NORM_CYC < 2 || WD_NORM_CYC > WD_INIT_CYC) begin : g_bad_wd
      $error("ssrw_supervisor: need 2 <= WD_NORM_CYC <= WD_INIT_CYC");
    end
  endgenerate

  // true when any bit of a channel vector is set
  function automatic logic any_set(input logic [CHANNELS-1:0] v);
    any_set = |v;
  endfunction : any_set

  // ------------------------------------------------------------------
  // channel flags
  // ------------------------------------------------------------------
  logic [CHANNELS-1:0] under_vec;
  logic [CHANNELS-1:0] over_vec;

  // each channel feeds its own pair of flags, never shared
  genvar gi;
  generate
    for (gi = 0; gi < CHANNELS; gi++) begin : g_ch
      assign under_vec[gi] = monitor_channel[gi].under_v;
      assign over_vec[gi]  = monitor_channel[gi].over_v;
    end
  endgenerate

  logic step;
  logic rst_cause;
  logic ov_cause;

  // hold-state stops every counter, so no output moves and manual reset is moot
  assign step      = clk_en & hold_state_n;
  assign rst_cause = any_set(under_vec) | ~manual_reset_req_n;
  assign ov_cause  = any_set(over_vec);

  // ------------------------------------------------------------------
  // reset and alarm stretchers
  // ------------------------------------------------------------------
  logic rst_active;
  logic ov_active;

  ssrw_stretch #(
    .COUNT (RST_HOLD_CYC)
  ) u_rst_stretch (
    .clock  (clock),
    .rst    (rst),
    .step   (step),
    .cause  (rst_cause),
    .active (rst_active)
  );

  ssrw_stretch #(
    .COUNT (OV_HOLD_CYC)
  ) u_ov_stretch (
    .clock  (clock),
    .rst    (rst),
    .step   (step),
    .cause  (ov_cause),
    .active (ov_active)
  );

  // stretcher outputs are flops already, so the pins come straight off them
  assign system_reset_n       = rst_active ? ssrw_pkg::OUT_ON : ssrw_pkg::OUT_OFF;
  assign overvoltage_alarm_n  = ov_active ? ssrw_pkg::OUT_ON : ssrw_pkg::OUT_OFF;
  assign system_reset_oe      = rst_active;
  assign overvoltage_alarm_oe = ov_active;

  // ------------------------------------------------------------------
  // watchdog strobe edge detect
  // ------------------------------------------------------------------
  logic strobe_prev_r;
  logic strobe_valid_r;
  logic strobe_edge;

  // the first sample after reset only primes the history, so a strobe
  // pin parked high is not mistaken for an edge
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      strobe_prev_r  <= 1'b0;
      strobe_valid_r <= 1'b0;
    end else if (clk_en) begin
      strobe_prev_r  <= watchdog_strobe_in;
      strobe_valid_r <= 1'b1;
    end
  end

  assign strobe_edge = strobe_valid_r & (watchdog_strobe_in != strobe_prev_r);

  // ------------------------------------------------------------------
  // watchdog timer
  // ------------------------------------------------------------------
  logic [WD_W-1:0] wd_cnt_r;
  logic [WD_W-1:0] wd_limit;
  logic            wd_seen_r;
  logic            wd_exp_r;

  // long period until the host shows life, short one after
  assign wd_limit = wd_seen_r ? WD_W'(WD_NORM_CYC) : WD_W'(WD_INIT_CYC);

  // count stops once expired; only a strobe restarts it
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wd_cnt_r  <= '0;
      wd_seen_r <= 1'b0;
      wd_exp_r  <= 1'b0;
    end else if (step) begin
      if (strobe_edge) begin
        wd_cnt_r  <= '0;
        wd_seen_r <= 1'b1;
        wd_exp_r  <= 1'b0;
      end else if (!wd_exp_r) begin
        if (wd_cnt_r == wd_limit - 1'b1) begin
          wd_exp_r <= 1'b1;
        end else begin
          wd_cnt_r <= wd_cnt_r + 1'b1;
        end
      end
    end
  end

  assign watchdog_expired_n  = wd_exp_r ? ssrw_pkg::OUT_ON : ssrw_pkg::OUT_OFF;
  assign watchdog_expired_oe = wd_exp_r;

  // ------------------------------------------------------------------
  // assertion helpers: cycles since each cause was last seen
  // ------------------------------------------------------------------
  logic [63:0] rst_quiet_r;
  logic [63:0] ov_quiet_r;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rst_quiet_r <= '0;
      ov_quiet_r  <= '0;
    end else if (step) begin
      rst_quiet_r <= rst_cause ? '0 : rst_quiet_r + 64'h1;
      ov_quiet_r  <= ov_cause ? '0 : ov_quiet_r + 64'h1;
    end
  end

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  sequence s_live;
    clk_en && hold_state_n;
  endsequence

  sequence s_frozen;
    clk_en && !hold_state_n;
  endsequence

  property p_uv_reset;
    @(posedge clock) disable iff (rst)
      (s_live and any_set(under_vec)) |=> !system_reset_n;
  endproperty
  a_uv_reset: assert property (p_uv_reset) else $error("undervoltage did not reset");

  property p_mr_reset;
    @(posedge clock) disable iff (rst)
      (s_live and !manual_reset_req_n) ##1 1'b1 |-> !system_reset_n && system_reset_oe;
  endproperty
  a_mr_reset: assert property (p_mr_reset) else $error("manual reset ignored");

  property p_rst_hold;
    @(posedge clock) disable iff (rst)
      $rose(system_reset_n) |-> rst_quiet_r == RST_HOLD_CYC;
  endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("reset released early or late");

  property p_ov_alarm;
    @(posedge clock) disable iff (rst)
      (s_live and ov_cause) |=> !overvoltage_alarm_n;
  endproperty
  a_ov_alarm: assert property (p_ov_alarm) else $error("overvoltage alarm missing");

  property p_ov_hold;
    @(posedge clock) disable iff (rst)
      $rose(overvoltage_alarm_n) |-> ov_quiet_r == OV_HOLD_CYC;
  endproperty
  a_ov_hold: assert property (p_ov_hold) else $error("alarm released early or late");

  property p_wd_expire;
    @(posedge clock) disable iff (rst)
      $fell(watchdog_expired_n) |->
        $past(wd_cnt_r) == (wd_seen_r ? WD_NORM_CYC - 1 : WD_INIT_CYC - 1);
  endproperty
  a_wd_expire: assert property (p_wd_expire) else $error("watchdog period wrong");

  property p_wd_strobe;
    @(posedge clock) disable iff (rst)
      (s_live and strobe_edge) |=> watchdog_expired_n && wd_cnt_r == '0 && wd_seen_r;
  endproperty
  a_wd_strobe: assert property (p_wd_strobe) else $error("strobe did not restart");

  property p_freeze;
    @(posedge clock) disable iff (rst)
      s_frozen |=> $stable(system_reset_n) && $stable(overvoltage_alarm_n)
                   && $stable(watchdog_expired_n);
  endproperty
  a_freeze: assert property (p_freeze) else $error("output moved during hold");

  property p_hold_beats_mr;
    @(posedge clock) disable iff (rst)
      (s_frozen and !manual_reset_req_n and system_reset_n) |=> system_reset_n;
  endproperty
  a_hold_beats_mr: assert property (p_hold_beats_mr) else $error("reset during hold");

endmodule : ssrw_supervisor

`default_nettype wire
